// File: hdl/plsb_pkg.sv
// Constants shared by the loop status and boot status register group.
package plsb_pkg;
    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned SYNC_W          = 12;
    localparam int unsigned PHASE_W         = 16;
    localparam int unsigned IRQ_W           = 8;

    localparam logic [11:0] ADDR_REF_STATUS = 12'h205;
    localparam logic [11:0] ADDR_LOOP_STATE = 12'h206;
    localparam logic [11:0] ADDR_GPI        = 12'h219;
    localparam logic [11:0] ADDR_IRQ_SUM    = 12'h21a;
    localparam logic [11:0] ADDR_BOOT_FAIL  = 12'h21e;
    localparam logic [11:0] ADDR_EEP_STATUS = 12'h21f;

    // Bit positions inside the status bytes.
    localparam int unsigned POS_FB_LOSS     = 4;
    localparam int unsigned POS_NO_REF      = 3;
    localparam int unsigned POS_LOCKED      = 4;
    localparam int unsigned POS_IRQ_SUM     = 0;
    localparam int unsigned POS_BOOT_FAIL   = 0;
    localparam int unsigned POS_CRC_GOOD    = 3;
    localparam int unsigned POS_LOAD_DONE   = 0;

    localparam logic [2:0]  REF_NONE        = 3'h0;
    localparam logic [2:0]  REF_FIRST       = 3'h4;
    localparam logic [2:0]  REF_SECOND      = 3'h5;
    localparam logic [1:0]  STATE_FREE_RUN  = 2'h1;
    localparam logic [1:0]  STATE_NORMAL    = 2'h2;
    localparam logic [1:0]  STATE_HOLDOVER  = 2'h3;

    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    localparam int unsigned SYNC_LATENCY    = 3;
endpackage

// File: hdl/plsb_sync.sv
// Two flip-flop synchroniser for a vector of independent level signals.
`timescale 1ns/1ps
`default_nettype none
module plsb_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// File: hdl/plsb_status_regs.sv
// Read-only loop status, input level, interrupt summary and boot load status registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01: The feedback-loss flag reads 1 while the loop has lost its feedback reference and 0 otherwise.
// R02: The no-valid-reference flag reads 1 when no input reference is valid and 0 when any is.
// R03: The selected reference reads 100 for the first input, 101 for the second and 000 when none.
// R04: The locked bit is set while the phase error magnitude is below the programmed lock window.
// R05: The locked bit stays clear whenever the loop runs in synthesizer mode.
// R06: The loop state reads 01 free-run, 10 normal, 11 holdover, and never the reserved 00.
// R07: The general-input register returns the level of each of four pins configured as input.
// R08: The summary bit is 1 and the interrupt pin pulled low while any enabled status bit is set.
// R09: The boot-read-failed bit is set by a failed EEPROM read and held until reset.
// R10: The load-complete bit is set when the EEPROM read cycle ends and held until reset.
// R11: The active-low checksum bit drops to 0 on a CRC failure, locking the serial port until reset.
// R12: The host writes zero to reserved bits and ignores their read value.
// R13: Loop status follows the live loop with no snapshot, so fields may disagree mid-change.
// R14: Loop and pin-level sources pass through two flip-flops before they can be read; phase error, interrupt and EEPROM inputs do not.
module plsb_status_regs
    import plsb_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               feedback_lost,
    input  wire logic [1:0]         ref_valid,
    input  wire logic               ref_selected,
    input  wire logic               ref_second_sel,
    input  wire logic               synth_mode,
    input  wire logic               state_normal,
    input  wire logic               state_holdover,
    input  wire logic [PHASE_W-1:0] phase_err_mag,
    input  wire logic [PHASE_W-1:0] lock_window,
    input  wire logic [3:0]         gpio_level,
    input  wire logic [3:0]         gpio_is_input,
    input  wire logic [IRQ_W-1:0]   irq_status,
    input  wire logic [IRQ_W-1:0]   irq_enable,
    input  wire logic               eeprom_read_fail,
    input  wire logic               eeprom_read_done,
    input  wire logic               eeprom_crc_fail,
    input  wire logic               rd_en,
    input  wire logic [ADDR_W-1:0]  rd_addr,
    output var  logic [DATA_W-1:0]  rd_data,
    output var  logic               rd_valid,
    output var  logic               irq_pin_n_o,
    output var  logic               irq_pin_n_oe,
    output var  logic               serial_port_locked
);
    logic [SYNC_W-1:0] raw_vec;
    logic [SYNC_W-1:0] sync_vec;
    logic [3:0]        gpi_s;
    logic              fb_lost_s;
    logic [1:0]        ref_valid_s;
    logic              ref_sel_s;
    logic              ref_second_s;
    logic              synth_s;
    logic              normal_s;
    logic              hold_s;

    logic              feedback_loss_flag;
    logic              no_valid_reference;
    logic [2:0]        selected_reference_code;
    logic              loop_locked;
    logic [1:0]        loop_state_code;
    logic [3:0]        general_input_levels;
    logic              irq_summary;
    logic              boot_read_failed;
    logic              config_load_complete;
    logic              config_checksum_good;

    logic [2:0]        next_ref_code;
    logic [1:0]        next_state_code;
    logic              next_locked;
    logic              next_irq_summary;
    logic [7:0]        reg_ref_status;
    logic [7:0]        reg_loop_state;
    logic [7:0]        reg_gpi;
    logic [7:0]        reg_irq_sum;
    logic [7:0]        reg_boot_fail;
    logic [7:0]        reg_eep_status;
    logic [7:0]        next_rd_data;

    assign raw_vec = {gpio_level, feedback_lost, ref_valid, ref_selected, ref_second_sel,
                      synth_mode, state_normal, state_holdover};

    plsb_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (raw_vec),
        .sync_out (sync_vec)
    ); // [R14]

    assign {gpi_s, fb_lost_s, ref_valid_s, ref_sel_s, ref_second_s, synth_s, normal_s,
            hold_s} = sync_vec;

    assign next_ref_code    = !ref_sel_s   ? REF_NONE :
                              ref_second_s ? REF_SECOND : REF_FIRST; // [R03]
    // Holdover wins over normal; anything else is shown as free-run, never 00.
    assign next_state_code  = hold_s   ? STATE_HOLDOVER :
                              normal_s ? STATE_NORMAL : STATE_FREE_RUN; // [R06]
    assign next_locked      = !synth_s && (phase_err_mag < lock_window); // [R04] [R05]
    assign next_irq_summary = |(irq_status & irq_enable); // [R08]

    // Loop fields are refreshed every cycle from the live sources, never frozen on read.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            feedback_loss_flag      <= 1'b0;
            no_valid_reference      <= 1'b0;
            selected_reference_code <= REF_NONE;
            loop_locked             <= 1'b0;
            loop_state_code         <= STATE_FREE_RUN;
            general_input_levels    <= 4'h0;
            irq_summary             <= 1'b0;
        end
        else
        begin
            feedback_loss_flag      <= fb_lost_s; // [R01] [R13]
            no_valid_reference      <= ~|ref_valid_s; // [R02]
            selected_reference_code <= next_ref_code; // [R03]
            loop_locked             <= next_locked; // [R04] [R05]
            loop_state_code         <= next_state_code; // [R06]
            general_input_levels    <= gpi_s & gpio_is_input; // [R07]
            irq_summary             <= next_irq_summary; // [R08]
        end
    end

    // Boot results are sticky; only reset clears them.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            boot_read_failed     <= 1'b0;
            config_load_complete <= 1'b0;
            config_checksum_good <= 1'b1;
        end
        else
        begin
            boot_read_failed     <= boot_read_failed | eeprom_read_fail; // [R09]
            config_load_complete <= config_load_complete | eeprom_read_done; // [R10]
            config_checksum_good <= config_checksum_good & ~eeprom_crc_fail; // [R11]
        end
    end

    // Reserved bit positions read back as zero.
    assign reg_ref_status = {3'h0, feedback_loss_flag, no_valid_reference,
                             selected_reference_code};
    assign reg_loop_state = {3'h0, loop_locked, 2'h0, loop_state_code};
    assign reg_gpi        = {4'h0, general_input_levels};
    assign reg_irq_sum    = {7'h00, irq_summary};
    assign reg_boot_fail  = {7'h00, boot_read_failed};
    assign reg_eep_status = {4'h0, config_checksum_good, 2'h0, config_load_complete};

    assign next_rd_data = (rd_addr == ADDR_REF_STATUS) ? reg_ref_status :
                          (rd_addr == ADDR_LOOP_STATE) ? reg_loop_state :
                          (rd_addr == ADDR_GPI)        ? reg_gpi :
                          (rd_addr == ADDR_IRQ_SUM)    ? reg_irq_sum :
                          (rd_addr == ADDR_BOOT_FAIL)  ? reg_boot_fail :
                          (rd_addr == ADDR_EEP_STATUS) ? reg_eep_status : RESET_BYTE;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rd_data            <= RESET_BYTE;
            rd_valid           <= 1'b0;
            irq_pin_n_o        <= 1'b0;
            irq_pin_n_oe       <= 1'b0;
            serial_port_locked <= 1'b0;
        end
        else
        begin
            rd_valid           <= rd_en;
            if (rd_en)
            begin
                rd_data <= next_rd_data;
            end
            irq_pin_n_o        <= 1'b0;
            irq_pin_n_oe       <= next_irq_summary; // [R08]
            serial_port_locked <= ~config_checksum_good | eeprom_crc_fail; // [R11]
        end
    end

    // Cycles since reset release, saturating, so checks skip the synchroniser fill.
    logic [2:0] warm;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            warm <= 3'h0;
        end
        else if (warm != 3'h7)
        begin
            warm <= warm + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    fb_loss_track_a: assert property ((warm == 3'h7) |-> // [R01]
        feedback_loss_flag == $past(feedback_lost, 3))
        else $error("feedback loss flag does not follow its source");
    no_ref_track_a: assert property ((warm == 3'h7) |-> // [R02]
        no_valid_reference == ($past(ref_valid, 3) == 2'h0))
        else $error("no valid reference flag wrong");
    ref_code_legal_a: assert property (selected_reference_code == REF_NONE || // [R03]
        selected_reference_code == REF_FIRST || selected_reference_code == REF_SECOND)
        else $error("selected reference code illegal");
    // The warm guard skips the first edge after reset, where the bit still holds its reset value.
    lock_window_a: assert property ((warm != 3'h0) |-> // [R04]
        loop_locked == $past(!synth_s && phase_err_mag < lock_window))
        else $error("lock bit disagrees with the lock window");
    synth_unlock_a: assert property ($past(synth_s) |-> !loop_locked) // [R05]
        else $error("lock bit set in synthesizer mode");
    state_not_zero_a: assert property (loop_state_code != 2'h0) // [R06]
        else $error("reserved loop state reported");
    gpi_track_a: assert property ((warm == 3'h7) |-> // [R07]
        general_input_levels == ($past(gpio_level, 3) & $past(gpio_is_input)))
        else $error("general input levels wrong");
    irq_pin_a: assert property ((warm != 3'h0) |-> // [R08]
        irq_pin_n_oe == (|($past(irq_status) & $past(irq_enable))) &&
        irq_summary == irq_pin_n_oe && !irq_pin_n_o)
        else $error("interrupt pin disagrees with summary");
    boot_fail_set_a: assert property (eeprom_read_fail |=> boot_read_failed) // [R09]
        else $error("boot failed bit not set");
    boot_fail_hold_a: assert property (boot_read_failed |=> boot_read_failed [*8]) // [R09]
        else $error("boot failed bit cleared without reset");
    load_done_a: assert property (eeprom_read_done |=> config_load_complete) // [R10]
        else $error("load complete bit not set");
    load_done_hold_a: assert property (config_load_complete |=> config_load_complete [*8]) // [R10]
        else $error("load complete bit cleared without reset");
    crc_lock_a: assert property (eeprom_crc_fail |=> // [R11]
        !config_checksum_good && serial_port_locked ##1 serial_port_locked)
        else $error("crc failure did not lock the port");
endmodule
`default_nettype wire

// File: verif/plsb_boot_model.sv
// Boot configuration EEPROM model that reports one load outcome per request.
`timescale 1ns/1ps
`default_nettype none
module plsb_boot_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       go,
    input  wire logic [1:0] outcome,
    output var  logic       eeprom_read_done,
    output var  logic       eeprom_read_fail,
    output var  logic       eeprom_crc_fail
);
    // Outcome 0 loads cleanly, 1 ends with a bad CRC and 2 aborts the read.
    always_ff @(posedge clk)
    begin
        eeprom_read_done <= reset_n && go;
        eeprom_crc_fail  <= reset_n && go && outcome == 2'h1;
        eeprom_read_fail <= reset_n && go && outcome == 2'h2;
    end
endmodule
`default_nettype wire

// File: verif/plsb_status_regs_tb.sv
// Self-checking bench for the loop status and boot status registers.
`timescale 1ns/1ps
`default_nettype none
module plsb_status_regs_tb
    import plsb_pkg::*;
    ;
    logic               clk = 1'b0, reset_n = 1'b0, feedback_lost = 1'b0, ref_selected = 1'b0;
    logic               ref_second_sel = 1'b0, synth_mode = 1'b0, state_normal = 1'b0;
    logic               state_holdover = 1'b0, rd_en = 1'b0, go = 1'b0;
    logic [1:0]         ref_valid = 2'h0, outcome = 2'h0;
    logic [3:0]         gpio_level = 4'h0, gpio_is_input = 4'h0;
    logic [PHASE_W-1:0] phase_err_mag = 16'h0000, lock_window = 16'h0000;
    logic [IRQ_W-1:0]   irq_status = 8'h00, irq_enable = 8'h00;
    logic [ADDR_W-1:0]  rd_addr = 12'h000;
    logic [DATA_W-1:0]  rd_data;
    logic               rd_valid, irq_pin_n_o, irq_pin_n_oe, serial_port_locked;
    logic               eeprom_read_done, eeprom_read_fail, eeprom_crc_fail;
    int                 fail_count = 0, checks = 0;

    always #5 clk = ~clk;

    plsb_boot_model i_eeprom (.clk, .reset_n, .go, .outcome, .eeprom_read_done,
        .eeprom_read_fail, .eeprom_crc_fail);

    plsb_status_regs i_dut (.clk, .reset_n, .feedback_lost, .ref_valid, .ref_selected,
        .ref_second_sel, .synth_mode, .state_normal, .state_holdover, .phase_err_mag,
        .lock_window, .gpio_level, .gpio_is_input, .irq_status, .irq_enable,
        .eeprom_read_fail, .eeprom_read_done, .eeprom_crc_fail, .rd_en, .rd_addr,
        .rd_data, .rd_valid, .irq_pin_n_o, .irq_pin_n_oe, .serial_port_locked);

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One read, started on a clock edge; the answer is taken at the edge where rd_valid stands.
    // The host side only reads, so no reserved bit is ever written.
    task rd(input logic [11:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        while (rd_valid !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 4)
        begin
            fail_count++;
            $display("MISMATCH t=%0t read answer missing", $time);
            report_and_stop;
        end
        else
        begin
            chk(rd_data, exp);
        end
    endtask

    // Level inputs reach the registers after the synchroniser latency.
    task wt;
        repeat (SYNC_LATENCY + 1) @(posedge clk);
    endtask

    task boot(input logic [1:0] o);
        @(posedge clk);
        outcome <= o;
        go      <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wt;
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd(ADDR_EEP_STATUS, 8'h08);
        rd(ADDR_BOOT_FAIL, 8'h00);
        rd(ADDR_IRQ_SUM, 8'h00);
        rd(12'h207, 8'h00);
        $display("test reset values done");
        feedback_lost  <= 1'b1;
        ref_selected   <= 1'b1;
        ref_second_sel <= 1'b1;
        state_normal   <= 1'b1;
        state_holdover <= 1'b1;
        wt;
        rd(ADDR_REF_STATUS, 8'h1d);
        rd(ADDR_LOOP_STATE, 8'h03);
        feedback_lost  <= 1'b0;
        ref_valid      <= 2'h2;
        ref_second_sel <= 1'b0;
        state_holdover <= 1'b0;
        phase_err_mag  <= 16'h0009;
        lock_window    <= 16'h000a;
        wt;
        rd(ADDR_REF_STATUS, 8'h04);
        rd(ADDR_LOOP_STATE, 8'h12);
        ref_selected  <= 1'b0;
        state_normal  <= 1'b0;
        phase_err_mag <= 16'h000a;
        wt;
        rd(ADDR_REF_STATUS, 8'h00);
        rd(ADDR_LOOP_STATE, 8'h01);
        phase_err_mag <= 16'h0000;
        synth_mode    <= 1'b1;
        wt;
        rd(ADDR_LOOP_STATE, 8'h01);
        $display("test loop status done");
        gpio_level    <= 4'hb;
        gpio_is_input <= 4'h7;
        wt;
        rd(ADDR_GPI, 8'h03);
        irq_status <= 8'h84;
        irq_enable <= 8'h04;
        wt;
        rd(ADDR_IRQ_SUM, 8'h01);
        chk({6'h00, irq_pin_n_oe, irq_pin_n_o}, 8'h02);
        irq_enable <= 8'h03;
        wt;
        rd(ADDR_IRQ_SUM, 8'h00);
        chk({7'h00, irq_pin_n_oe}, 8'h00);
        $display("test interrupt done");
        boot(2'h0);
        rd(ADDR_EEP_STATUS, 8'h09);
        chk({7'h00, serial_port_locked}, 8'h00);
        boot(2'h1);
        rd(ADDR_EEP_STATUS, 8'h01);
        chk({7'h00, serial_port_locked}, 8'h01);
        boot(2'h2);
        wt;
        rd(ADDR_BOOT_FAIL, 8'h01);
        rd(ADDR_EEP_STATUS, 8'h01);
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd(ADDR_EEP_STATUS, 8'h08);
        rd(ADDR_BOOT_FAIL, 8'h00);
        chk({7'h00, serial_port_locked}, 8'h00);
        $display("test boot status done");
        report_and_stop;
    end
endmodule
`default_nettype wire
